// file: rtl/mad_pkg.sv
// Purpose: shared constants of the move / multiply-negate alias decoder
// Assumes: 32-bit instruction words, 64-bit general-purpose registers
// Notes:   masks ignore bit 31 (width flag), which selects operand size
package mad_pkg;

    localparam int unsigned INSTR_W       = 32;
    localparam int unsigned DATA_W        = 64;
    localparam int unsigned HALF_W        = 32;
    localparam int unsigned IDX_W         = 5;
    localparam int unsigned IMM_W         = 16;

    // field positions
    localparam int unsigned WIDTH_FLAG_BIT = 31;
    localparam int unsigned SUB_SEL_BIT    = 15;
    localparam int unsigned ELEM_FLAG_BIT  = 22;
    localparam int unsigned HSEL_HI        = 22;
    localparam int unsigned HSEL_LO        = 21;
    localparam int unsigned IMM_HI         = 20;
    localparam int unsigned IMM_LO         = 5;
    localparam int unsigned ROT_HI         = 21;
    localparam int unsigned ROT_LO         = 16;
    localparam int unsigned SIZE_HI        = 15;
    localparam int unsigned SIZE_LO        = 10;
    localparam int unsigned SRC2_HI        = 20;
    localparam int unsigned SRC2_LO        = 16;
    localparam int unsigned SRC1_HI        = 9;
    localparam int unsigned SRC1_LO        = 5;
    localparam int unsigned DST_HI         = 4;
    localparam int unsigned DST_LO         = 0;

    // alias opcode patterns
    localparam logic [31:0] MULNEG_MASK  = 32'h7fe0fc00;
    localparam logic [31:0] MULNEG_MATCH = 32'h1b00fc00;
    localparam logic [31:0] BMSK_MASK  = 32'h7f8003e0;
    localparam logic [31:0] BMSK_MATCH = 32'h320003e0;
    localparam logic [31:0] IWM_MASK   = 32'h7f800000;
    localparam logic [31:0] IWM_MATCH  = 32'h12800000;
    localparam logic [31:0] RMOV_MASK  = 32'h7fe0ffe0;
    localparam logic [31:0] RMOV_MATCH = 32'h2a0003e0;

    localparam logic [4:0]  ZERO_REG_IDX = 5'h1f;
    localparam logic [3:0]  HSEL_POS_ZEROS = 4'h0;

    typedef enum logic [2:0] {
        MAD_OP_NONE = 3'b000,
        MAD_OP_MULNEG = 3'b001,
        MAD_OP_BMSK = 3'b010,
        MAD_OP_IWM  = 3'b011,
        MAD_OP_RMOV = 3'b100
    } mad_op_t;

endpackage

// file: rtl/mad_bitmask.sv
// Purpose: expand an element-size / size / rotate triple into a 64-bit mask
// Assumes: purely combinational, same cost for every input value
// Notes:   o_reserved flags encodings the logical-immediate form rejects
`timescale 1ns/1ps
module mad_bitmask
(
    input  wire logic                        i_elem_flag,
    input  wire logic [5:0]                  i_size,
    input  wire logic [5:0]                  i_rot,
    output logic      [mad_pkg::DATA_W-1:0]  o_mask,
    output logic                             o_reserved
);

    logic [6:0] len_vec;
    logic [2:0] len;
    logic [5:0] levels;
    logic [5:0] s_val;
    logic [5:0] r_val;
    logic [5:0] pos;

    always_comb
    begin
        len_vec = {i_elem_flag, ~i_size};
        len     = 3'h0;
        for (int k = 0; k < 7; k++)
        begin
            if (len_vec[k])
            begin
                len = k[2:0];
            end
        end
        levels     = 6'(( 7'h01 << len) - 7'h01);
        s_val      = i_size & levels;
        r_val      = i_rot & levels;
        o_reserved = (len_vec == 7'h00) || (len == 3'h0) || (s_val == levels);
        // rotate right by r inside each element, then replicate
        for (int i = 0; i < 64; i++)
        begin
            pos       = (6'(i) + r_val) & levels;
            o_mask[i] = (pos <= s_val);
        end
    end

endmodule // mad_bitmask

// file: rtl/mad_decode.sv
// Purpose: decode and execute the move and multiply-negate alias group
// Assumes: register file read is combinational; source index 31 reads zero
// Notes:   fixed one-cycle latency from i_valid to o_valid for every form
`timescale 1ns/1ps
// Notes on behaviour
// - bit 31 picks 32-bit operation when clear and 64-bit when set.
// - multiply-negate multiplies both sources, negates and writes the result at the width.
// - multiply-negate runs as multiply-subtract with bit 15 set and the zero register as addend.
// - bitmask move is an immediate OR with the zero register as first source, field 9..5 all ones.
// - the 32-bit bitmask move needs element flag 0; the 64-bit form also decodes that flag.
// - the bitmask move may name the stack pointer as destination in both widths.
// - inverted wide move writes the inverse of the shifted 16-bit immediate.
// - the 32-bit inverted wide move is accepted only with the upper halfword-select bit clear.
// - in 64-bit form the shift is halfword-select times 16: 0, 16, 32 or 48.
// - register move ORs the zero register with the source in bits 20..16, shift zero.
// - the destination number comes from bits 4..0 of every alias.
// - execution time is the same whatever the data or condition flags.
// - response to asynchronous exceptions ignores data and condition flags.
// - a 32-bit inverted wide move with the upper halfword-select bit set is undefined.
// - the immediate sits at halfword-select followed by four zeros, rest zero, then inverted.
module mad_decode
(
    input  wire logic                          i_clk,
    input  wire logic                          i_rst_n,
    input  wire logic                          i_valid,
    input  wire logic [mad_pkg::INSTR_W-1:0]   i_instr,
    input  wire logic [mad_pkg::DATA_W-1:0]    i_src1_data,
    input  wire logic [mad_pkg::DATA_W-1:0]    i_src2_data,
    output logic      [mad_pkg::IDX_W-1:0]     o_src1_idx,
    output logic      [mad_pkg::IDX_W-1:0]     o_src2_idx,
    output logic                               o_valid,
    output logic                               o_match,
    output logic                               o_undef,
    output logic                               o_wr_en,
    output logic                               o_wr_sp,
    output logic      [mad_pkg::IDX_W-1:0]     o_wr_idx,
    output logic      [mad_pkg::DATA_W-1:0]    o_wr_data
);

    typedef struct packed {
        logic                         valid;
        logic                         match;
        logic                         undef;
        logic                         wr_en;
        logic                         wr_sp;
        logic [mad_pkg::IDX_W-1:0]    wr_idx;
        logic [mad_pkg::DATA_W-1:0]   wr_data;
    } mad_state_t;

    mad_state_t                        st_reg;
    mad_state_t                        st_next;
    mad_pkg::mad_op_t                  op;
    logic                              wide;
    logic [mad_pkg::DATA_W-1:0]        op_a;
    logic [mad_pkg::DATA_W-1:0]        op_b;
    logic [mad_pkg::DATA_W-1:0]        product;
    logic [mad_pkg::DATA_W-1:0]        result;
    logic [mad_pkg::DATA_W-1:0]        bmask;
    logic                              bmask_rsv;
    logic [1:0]                        hsel;
    logic [mad_pkg::IMM_W-1:0]         wide_imm;
    logic [mad_pkg::IDX_W-1:0]         dst;
    logic                              undef;

    function automatic logic hit(input logic [31:0] instr, input logic [31:0] mask,
                                 input logic [31:0] match);
        hit = (instr & mask) == match;
    endfunction

    // 32-bit forms see and leave only the low word; upper half reads as zero
    function automatic logic [63:0] narrow(input logic [63:0] value, input logic is_wide);
        if (is_wide)
        begin
            narrow = value;
        end
        else
        begin
            narrow = {32'h0, value[31:0]};
        end
    endfunction

    // zero register stands in for index 31 on every source read
    function automatic logic [63:0] src_val(input logic [4:0] idx, input logic [63:0] data,
                                            input logic is_wide);
        if (idx == mad_pkg::ZERO_REG_IDX)
        begin
            src_val = 64'h0;
        end
        else
        begin
            src_val = narrow(data, is_wide);
        end
    endfunction

    // immediate at select times 16, zeros elsewhere, then inverted
    function automatic logic [63:0] inv_wide(input logic [15:0] imm, input logic [1:0] sel);
        logic [5:0] pos;
        pos      = {sel, mad_pkg::HSEL_POS_ZEROS};
        inv_wide = ~({48'h0, imm} << pos);
    endfunction

    // a 32-bit bitmask move may not ask for a 64-bit element
    function automatic logic bmask_bad(input logic reserved, input logic is_wide,
                                       input logic elem_flag);
        bmask_bad = reserved || (!is_wide && elem_flag);
    endfunction

    // destination 31 is the zero register except for the bitmask move
    function automatic logic dest_writable(input mad_pkg::mad_op_t kind, input logic [4:0] idx);
        dest_writable = (idx != mad_pkg::ZERO_REG_IDX) || (kind == mad_pkg::MAD_OP_BMSK);
    endfunction

    // first hit wins; the four patterns never overlap anyway
    function automatic mad_pkg::mad_op_t decode_op(input logic [31:0] instr);
        if (hit(instr, mad_pkg::MULNEG_MASK, mad_pkg::MULNEG_MATCH))
        begin
            decode_op = mad_pkg::MAD_OP_MULNEG;
        end
        else if (hit(instr, mad_pkg::BMSK_MASK, mad_pkg::BMSK_MATCH))
        begin
            decode_op = mad_pkg::MAD_OP_BMSK;
        end
        else if (hit(instr, mad_pkg::IWM_MASK, mad_pkg::IWM_MATCH))
        begin
            decode_op = mad_pkg::MAD_OP_IWM;
        end
        else if (hit(instr, mad_pkg::RMOV_MASK, mad_pkg::RMOV_MATCH))
        begin
            decode_op = mad_pkg::MAD_OP_RMOV;
        end
        else
        begin
            decode_op = mad_pkg::MAD_OP_NONE;
        end
    endfunction

    mad_bitmask u_bitmask
    (
        .i_elem_flag (i_instr[mad_pkg::ELEM_FLAG_BIT]),
        .i_size      (i_instr[mad_pkg::SIZE_HI:mad_pkg::SIZE_LO]),
        .i_rot       (i_instr[mad_pkg::ROT_HI:mad_pkg::ROT_LO]),
        .o_mask      (bmask),
        .o_reserved  (bmask_rsv)
    );

    assign o_src1_idx = i_instr[mad_pkg::SRC1_HI:mad_pkg::SRC1_LO];
    assign o_src2_idx = i_instr[mad_pkg::SRC2_HI:mad_pkg::SRC2_LO];

    always_comb
    begin
        wide     = i_instr[mad_pkg::WIDTH_FLAG_BIT];
        dst      = i_instr[mad_pkg::DST_HI:mad_pkg::DST_LO];
        hsel     = i_instr[mad_pkg::HSEL_HI:mad_pkg::HSEL_LO];
        wide_imm = i_instr[mad_pkg::IMM_HI:mad_pkg::IMM_LO];
        op       = decode_op(i_instr);

        // single-cycle datapath for every value; no early-out paths
        op_a    = src_val(o_src1_idx, i_src1_data, wide);
        op_b    = src_val(o_src2_idx, i_src2_data, wide);
        product = op_a * op_b;
        undef   = 1'b0;
        case (op)
            mad_pkg::MAD_OP_MULNEG:
            begin
                result = 64'h0 - product;
            end
            mad_pkg::MAD_OP_BMSK:
            begin
                result = 64'h0 | bmask;
                undef  = bmask_bad(bmask_rsv, wide, i_instr[mad_pkg::ELEM_FLAG_BIT]);
            end
            mad_pkg::MAD_OP_IWM:
            begin
                result = inv_wide(wide_imm, hsel);
                undef  = !wide && hsel[1];
            end
            mad_pkg::MAD_OP_RMOV:
            begin
                result = 64'h0 | op_b;
            end
            default:
            begin
                result = 64'h0;
            end
        endcase
        result = narrow(result, wide);

        st_next         = st_reg;
        st_next.valid   = i_valid;
        st_next.match   = i_valid && (op != mad_pkg::MAD_OP_NONE);
        st_next.undef   = i_valid && (op != mad_pkg::MAD_OP_NONE) && undef;
        st_next.wr_sp   = i_valid && (op == mad_pkg::MAD_OP_BMSK)
                          && (dst == mad_pkg::ZERO_REG_IDX) && !undef;
        st_next.wr_en   = i_valid && (op != mad_pkg::MAD_OP_NONE) && !undef
                          && dest_writable(op, dst);
        if (i_valid)
        begin
            st_next.wr_idx  = dst;
            st_next.wr_data = result;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            st_reg <= '0;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    assign o_valid   = st_reg.valid;
    assign o_match   = st_reg.match;
    assign o_undef   = st_reg.undef;
    assign o_wr_en   = st_reg.wr_en;
    assign o_wr_sp   = st_reg.wr_sp;
    assign o_wr_idx  = st_reg.wr_idx;
    assign o_wr_data = st_reg.wr_data;

endmodule // mad_decode

// file: sim/mad_regfile.sv
// Purpose: register file model feeding the decoder's read ports
// Assumes: combinational read, bench loads mem directly
// Notes:   index 31 holds junk; decoder must read it as zero
`timescale 1ns/1ps
module mad_regfile
(
    input  wire logic [4:0]  i_idx1,
    input  wire logic [4:0]  i_idx2,
    output logic      [63:0] o_data1,
    output logic      [63:0] o_data2
);
    logic [63:0] mem [32];
    assign o_data1 = mem[i_idx1];
    assign o_data2 = mem[i_idx2];
endmodule // mad_regfile

// file: sim/mad_decode_sva.sv
// Purpose: port checks of the alias decoder
// Assumes: one clock, async active-low reset
// Notes:   data checks skip zero-register operands
`timescale 1ns/1ps
module mad_decode_sva
(
    input wire logic        i_clk,
    input wire logic        i_rst_n,
    input wire logic        i_valid,
    input wire logic [31:0] i_instr,
    input wire logic [63:0] i_src1_data,
    input wire logic [63:0] i_src2_data,
    input wire logic [4:0]  o_src1_idx,
    input wire logic [4:0]  o_src2_idx,
    input wire logic        o_valid,
    input wire logic        o_match,
    input wire logic        o_undef,
    input wire logic        o_wr_en,
    input wire logic        o_wr_sp,
    input wire logic [4:0]  o_wr_idx,
    input wire logic [63:0] o_wr_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    logic [31:0] w;
    logic        mn;
    logic        bm;
    logic        iw;
    logic        rmv;
    logic        d_ok;
    logic        n_ok;
    logic        m_ok;
    assign w    = i_instr;
    assign mn   = i_valid && (w & mad_pkg::MULNEG_MASK) == mad_pkg::MULNEG_MATCH;
    assign bm   = i_valid && (w & mad_pkg::BMSK_MASK) == mad_pkg::BMSK_MATCH;
    assign iw   = i_valid && (w & mad_pkg::IWM_MASK) == mad_pkg::IWM_MATCH;
    assign rmv  = i_valid && (w & mad_pkg::RMOV_MASK) == mad_pkg::RMOV_MATCH;
    assign d_ok = w[4:0] != 5'h1f;
    assign n_ok = w[9:5] != 5'h1f;
    assign m_ok = w[20:16] != 5'h1f;
    fixed_latency_a: assert property (i_valid |=> o_valid)
        else $error("answer not one cycle later");
    no_spurious_a: assert property (!i_valid |=> !o_valid && !o_wr_en)
        else $error("answer without request");
    dest_index_a: assert property (i_valid |=> o_wr_idx == $past(w[4:0]))
        else $error("wrong destination index");
    narrow_upper_a: assert property (
        i_valid && !w[31] |=> !o_wr_en || o_wr_data[63:32] == 32'h0)
        else $error("upper half not zero");
    narrow_undef_a: assert property (
        iw && !w[31] && w[22] |=> o_undef && !o_wr_en)
        else $error("bad halfword select accepted");
    narrow_mask_a: assert property (
        bm && !w[31] && w[22] |=> o_undef && !o_wr_en)
        else $error("narrow bitmask move with wide element accepted");
    reg_move_a: assert property (
        rmv && w[31] && d_ok && m_ok |=> o_wr_en && o_wr_data == $past(i_src2_data))
        else $error("register move data wrong");
    wide_inv_a: assert property (
        iw && w[31] && d_ok |=>
        o_wr_data == ~({48'h0, $past(w[20:5])} << {$past(w[22:21]), 4'h0}))
        else $error("inverted wide data wrong");
    mul_neg_a: assert property (
        mn && w[31] && d_ok && n_ok && m_ok |=>
        o_wr_data == 64'h0 - $past(i_src1_data) * $past(i_src2_data))
        else $error("multiply-negate data wrong");
    sp_dest_a: assert property (o_wr_sp |-> o_wr_en && o_wr_idx == 5'h1f)
        else $error("stack pointer write malformed");
    undef_quiet_a: assert property (o_undef |-> o_match && !o_wr_en && !o_wr_sp)
        else $error("undefined word still writes");
    match_pulse_a: assert property (o_match |-> o_valid)
        else $error("match without answer");
endmodule // mad_decode_sva
bind mad_decode mad_decode_sva chk
(
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_instr(i_instr),
    .i_src1_data(i_src1_data), .i_src2_data(i_src2_data), .o_src1_idx(o_src1_idx),
    .o_src2_idx(o_src2_idx), .o_valid(o_valid), .o_match(o_match), .o_undef(o_undef),
    .o_wr_en(o_wr_en), .o_wr_sp(o_wr_sp), .o_wr_idx(o_wr_idx), .o_wr_data(o_wr_data)
);

// file: sim/move_and_mulneg_alias_decode_bench.sv
// Purpose: self-checking bench of the alias decoder
// Assumes: register file model on the read ports
// Notes:   flags compared as {valid, match, undef, wr_en, wr_sp}
`timescale 1ns/1ps
`define CHK(a, b) \
    begin \
        tests_run++; \
        if ((a) !== (b)) \
        begin \
            error_cnt++; \
            $display("wrong value t=%0t got %h exp %h", $time, (a), (b)); \
        end \
    end
module move_and_mulneg_alias_decode_bench;
    logic        i_clk, i_rst_n, i_valid;
    logic [31:0] i_instr;
    logic [63:0] i_src1_data, i_src2_data, o_wr_data;
    logic [4:0]  o_src1_idx, o_src2_idx, o_wr_idx;
    logic        o_valid, o_match, o_undef, o_wr_en, o_wr_sp;
    int          error_cnt = 0;
    int          tests_run = 0;
    mad_decode uut
    (
        .i_clk(i_clk), .i_rst_n(i_rst_n), .i_valid(i_valid), .i_instr(i_instr),
        .i_src1_data(i_src1_data), .i_src2_data(i_src2_data), .o_src1_idx(o_src1_idx),
        .o_src2_idx(o_src2_idx), .o_valid(o_valid), .o_match(o_match), .o_undef(o_undef),
        .o_wr_en(o_wr_en), .o_wr_sp(o_wr_sp), .o_wr_idx(o_wr_idx), .o_wr_data(o_wr_data)
    );
    mad_regfile rf
    (
        .i_idx1(o_src1_idx), .i_idx2(o_src2_idx), .o_data1(i_src1_data), .o_data2(i_src2_data)
    );
    initial
    begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end
    // one word, answer judged 1 ns after the edge that takes it
    task automatic run(input logic [31:0] w, input logic [3:0] f, input logic [63:0] d);
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_instr <= w;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        `CHK({o_valid, o_match, o_undef, o_wr_en, o_wr_sp}, {1'b1, f})
        `CHK(o_wr_idx, w[4:0])
        if (f[1]) `CHK(o_wr_data, d)
    endtask
    task automatic t_multiply_negate;
        run(32'h9b02fc23, 4'ha, 64'h0 - rf.mem[1] * rf.mem[2]);
        run(32'h1b02fc23, 4'ha, {32'h0, 32'h0 - rf.mem[1][31:0] * rf.mem[2][31:0]});
        run(32'h9b1ffc23, 4'ha, 64'h0);
        run(32'h9b027c23, 4'h0, 64'h0);
        run(32'h9b02fc3f, 4'h8, 64'h0);
        $display("multiply-negate test done");
    endtask
    task automatic t_bmsk;
        run(32'hb24003ff, 4'hb, 64'h1);
        run(32'h320003e5, 4'ha, 64'h1);
        run(32'hb20003e5, 4'ha, 64'h0000000100000001);
        run(32'h324003e5, 4'hc, 64'h0);
        run(32'hb24103e5, 4'ha, 64'h8000000000000000);
        run(32'h320103e5, 4'ha, 64'h0000000080000000);
        run(32'hb24003c5, 4'h0, 64'h0);
        run(32'hb240ffe5, 4'hc, 64'h0);
        run(32'hb200fbe5, 4'hc, 64'h0);
        $display("bitmask move test done");
    endtask
    task automatic t_iwm;
        for (int h = 0; h < 4; h++)
        begin
            run(32'h92800000 | (h << 21) | 32'h2468a, 4'ha,
                ~(64'h1234 << (h * 16)));
            run(32'h12800000 | (h << 21) | 32'h2468a, h < 2 ? 4'ha : 4'hc,
                {32'h0, ~(32'h1234 << (h * 16))});
        end
        $display("inverted wide move test done");
    endtask
    task automatic t_rmov;
        run(32'haa0703e4, 4'ha, rf.mem[7]);
        run(32'h2a0703e4, 4'ha, {32'h0, rf.mem[7][31:0]});
        run(32'haa1f03e4, 4'ha, 64'h0);
        run(32'haa0707e4, 4'h0, 64'h0);
        run(32'h00000000, 4'h0, 64'h0);
        $display("register move test done");
    endtask
    // back-to-back words: answers must not slip a cycle
    task automatic t_b2b;
        @(posedge i_clk);
        i_valid <= 1'b1;
        i_instr <= 32'h92800001;
        @(posedge i_clk);
        i_instr <= 32'haa0703e2;
        #1;
        `CHK({o_valid, o_wr_data}, {1'b1, ~64'h0})
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
        `CHK({o_valid, o_wr_idx, o_wr_data}, {1'b1, 5'h2, rf.mem[7]})
        $display("back-to-back test done");
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        i_rst_n = 1'b0;
        i_valid = 1'b0;
        i_instr = 32'h0;
        for (int i = 0; i < 32; i++)
            rf.mem[i] = 64'hf1e2d3c4b5a69788 * (i + 1);
        repeat (8) @(posedge i_clk);
        i_rst_n <= 1'b1;
        t_multiply_negate;
        t_bmsk;
        t_iwm;
        t_rmov;
        t_b2b;
        end_of_test;
    end
    // about 65 cycles of work; far beyond that means a hang
    initial
    begin
        #5000;
        error_cnt++;
        end_of_test;
    end
endmodule // move_and_mulneg_alias_decode_bench
